// File: core/brc_pkg.sv
// Constants for the bidirectional reset controller: register map, field positions, timing counts.
// Assumes one 50 MHz clock; one clock phase period is taken as one clock cycle.
package brc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CONFIG_ADDR      = 8'h00;
  localparam logic [7:0] FLAGS_ADDR       = 8'h04;
  localparam logic [7:0] IRQ_STATUS_ADDR  = 8'h08;
  localparam logic [7:0] IRQ_MASK_ADDR    = 8'h0c;

  localparam int BIDIR_EN_BIT  = 3;
  localparam int PWD_CFG_BIT   = 4;

  // Reset source flags
  localparam int FLAG_WDT   = 0;
  localparam int FLAG_SW    = 1;
  localparam int FLAG_SHORT = 2;
  localparam int FLAG_LONG  = 3;
  localparam int FLAG_ASYNC = 4;
  localparam int FLAG_INIT  = 8;
  localparam logic [4:0] SRC_SHORT = 5'h06;
  localparam logic [4:0] SRC_LONG  = 5'h0e;
  localparam logic [4:0] SRC_SW    = 5'h02;
  localparam logic [4:0] SRC_WDT   = 5'h03;
  localparam logic [4:0] SRC_ASYNC = 5'h1e;

  // Interrupt events
  localparam int EV_EXIT  = 0;
  localparam int EV_LONG  = 1;
  localparam int EV_DEGEN = 2;
  localparam int EV_ASYNC = 3;
  localparam int EV_W     = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS           = 20;
  localparam int PHASE_NS         = 20;
  localparam int CYC_PER_PHASE    = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEQ_PHASES       = 1024;
  localparam int SAMPLE_PHASES    = 8;
  localparam int SHORT_MIN_PHASES = 4;
  localparam int FLASH_PHASES     = 64;
  localparam int CNT_W            = 12;
  localparam logic [CNT_W-1:0] SEQ_CYC    = CNT_W'(SEQ_PHASES * CYC_PER_PHASE);
  localparam logic [CNT_W-1:0] SAMPLE_CYC = CNT_W'(SAMPLE_PHASES * CYC_PER_PHASE);
  localparam logic [CNT_W-1:0] SHORT_CYC  = CNT_W'(SHORT_MIN_PHASES * CYC_PER_PHASE);
  localparam logic [CNT_W-1:0] FLASH_CYC  = CNT_W'(FLASH_PHASES * CYC_PER_PHASE);

  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_SEQ   = 3'b001,
    ST_POST  = 3'b010,
    ST_LONG  = 3'b011,
    ST_FLASH = 3'b100,
    ST_ASYNC = 3'b101
  } brc_state_t;

  typedef enum logic [1:0] {
    KIND_HW  = 2'b00,
    KIND_SW  = 2'b01,
    KIND_WDT = 2'b10
  } brc_kind_t;

endpackage

// File: core/brc_top.sv
// Bidirectional reset controller with AXI4-Lite register access.
// Assumes pins arrive asynchronous to aclk; CPU pulses (software reset, watchdog, end of init) are on aclk.
`timescale 1ns/1ps
`default_nettype none
module brc_top
  import brc_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // CPU events
  input  wire logic        sw_reset_req,
  input  wire logic        wdt_reset_req,
  input  wire logic        end_of_init_instruction,
  // Pins
  input  wire logic        reset_input_pin_i,
  output logic             reset_input_pin_o,
  output logic             reset_input_pin_oe_n,
  output logic             reset_output_pin_n,
  input  wire logic        reset_power_down_pin_i,
  output logic             pdn_pulldown_en,
  output logic             pdn_pullup_en,
  input  wire logic        external_access_pin_n,
  // Internal
  output logic             system_reset_n,
  output logic             irq
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_meta_reg <= 3'h7;
      pin_sync_reg <= 3'h7;
    end
    else
    begin
      pin_meta_reg <= {external_access_pin_n, reset_power_down_pin_i, reset_input_pin_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  wire filtered_reset_input = pin_sync_reg[0];
  wire pdn_high             = pin_sync_reg[1];
  wire flash_boot           = pin_sync_reg[2];

  // ****************************************
  // State
  // ****************************************
  brc_state_t       state_reg;
  brc_state_t       state_next;
  brc_kind_t        kind_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] low_cnt_reg;
  logic             drive_reg;
  logic             bidir_seq_reg;
  logic             bidir_reset_enable;
  logic             power_down_config_bit;
  logic             init_done_reg;
  logic [4:0]       src_reg;
  logic [EV_W-1:0]  irq_status_reg;
  logic [EV_W-1:0]  irq_mask_reg;

  wire in_run      = (state_reg == ST_RUN);
  wire sw_kind     = (kind_reg != KIND_HW);
  wire cnt_last    = (cnt_reg == SEQ_CYC - CNT_W'(1));
  wire sample_last = (cnt_reg == SAMPLE_CYC - CNT_W'(1));
  wire flash_last  = (cnt_reg == FLASH_CYC - CNT_W'(1));

  // Asynchronous hardware reset: input asserted while the power-down pin is low
  wire start_async = !filtered_reset_input && !pdn_high && (state_reg != ST_ASYNC) &&
                     !((state_reg == ST_SEQ) && sw_kind);
  wire start_hw    = in_run && !start_async && (low_cnt_reg == SHORT_CYC);
  wire start_wdt   = in_run && !start_async && !start_hw && wdt_reset_req;
  wire start_sw    = in_run && !start_async && !start_hw && !wdt_reset_req && sw_reset_req;
  wire seq_start   = start_hw || start_wdt || start_sw;
  brc_state_t exit_state;
  assign exit_state = flash_boot ? ST_FLASH : ST_RUN;

  wire hw_end_long = cnt_last && !sw_kind && !bidir_seq_reg && !filtered_reset_input;
  wire post_long   = (state_reg == ST_POST) && sample_last && !filtered_reset_input;
  wire enter_long  = (state_reg == ST_SEQ && hw_end_long) || post_long;
  wire degen       = start_hw && src_reg[FLAG_SW] && !src_reg[FLAG_SHORT];
  wire enter_run   = (state_next == ST_RUN) && !in_run;

  always_comb
  begin
    state_next = state_reg;
    if (start_async)
      state_next = ST_ASYNC;
    else if (seq_start)
      state_next = ST_SEQ;
    else
    begin
      case (state_reg)
        ST_SEQ:
        begin
          if (cnt_last)
          begin
            if (!sw_kind && bidir_seq_reg)
              state_next = ST_POST;
            else if (hw_end_long)
              state_next = ST_LONG;
            else
              state_next = exit_state;
          end
        end
        ST_POST:
        begin
          if (sample_last)
            state_next = filtered_reset_input ? exit_state : ST_LONG;
        end
        ST_LONG, ST_ASYNC:
        begin
          if (filtered_reset_input)
            state_next = exit_state;
        end
        ST_FLASH:
        begin
          if (flash_last)
            state_next = ST_RUN;
        end
        default:
          state_next = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || seq_start || start_async || (state_next != state_reg))
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + CNT_W'(1);
  end

  // Consecutive low time on the filtered input while running
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !in_run || filtered_reset_input || start_hw)
      low_cnt_reg <= '0;
    else if (low_cnt_reg != SHORT_CYC)
      low_cnt_reg <= low_cnt_reg + CNT_W'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      kind_reg <= KIND_HW;
    else if (start_hw || start_async)
      kind_reg <= KIND_HW;
    else if (start_wdt)
      kind_reg <= KIND_WDT;
    else if (start_sw)
      kind_reg <= KIND_SW;
  end

  // ****************************************
  // Reset input pin open drain
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      drive_reg     <= 1'b0;
      bidir_seq_reg <= 1'b0;
    end
    else if (start_async)
    begin
      drive_reg     <= 1'b0;
      bidir_seq_reg <= 1'b0;
    end
    else if (seq_start)
    begin
      drive_reg     <= bidir_reset_enable && (start_hw || pdn_high);
      bidir_seq_reg <= bidir_reset_enable;
    end
    else if (state_reg != ST_SEQ || cnt_last)
      drive_reg <= 1'b0;
    else if (sw_kind && !pdn_high)
      drive_reg <= 1'b0;
  end

  // ****************************************
  // Configuration and flags
  // ****************************************
  wire [7:0] wr_addr;
  wire       wr_fire;
  wire       wr_cfg  = wr_fire && (wr_addr == CONFIG_ADDR) && s_axi_wstrb[0];
  wire       wr_ist  = wr_fire && (wr_addr == IRQ_STATUS_ADDR) && s_axi_wstrb[0];
  wire       wr_msk  = wr_fire && (wr_addr == IRQ_MASK_ADDR) && s_axi_wstrb[0];
  wire [31:0] wr_data;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || seq_start || start_async)
      bidir_reset_enable <= 1'b0;
    else if (wr_cfg && !init_done_reg)
      bidir_reset_enable <= wr_data[BIDIR_EN_BIT];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      power_down_config_bit <= 1'b0;
    else if (wr_cfg)
      power_down_config_bit <= wr_data[PWD_CFG_BIT];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || seq_start || start_async)
      init_done_reg <= 1'b0;
    else if (in_run && end_of_init_instruction)
      init_done_reg <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      src_reg <= SRC_ASYNC;
    else if (start_async)
      src_reg <= SRC_ASYNC;
    else if (start_hw)
      src_reg <= SRC_SHORT;
    else if (start_wdt)
      src_reg <= SRC_WDT;
    else if (start_sw)
      src_reg <= SRC_SW;
    else if (enter_long)
      src_reg <= SRC_LONG;
  end

  // ****************************************
  // Pin and system outputs
  // ****************************************
  // Drop the pull-down on the same edge that ends the sequence, never after it
  wire drive_now = drive_reg && (state_next == ST_SEQ) && !(sw_kind && !pdn_high);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reset_input_pin_o    <= 1'b0;
      reset_input_pin_oe_n <= 1'b1;
      reset_output_pin_n   <= 1'b0;
      pdn_pulldown_en      <= 1'b0;
      pdn_pullup_en        <= 1'b0;
      system_reset_n       <= 1'b0;
    end
    else
    begin
      reset_input_pin_o    <= 1'b0;
      reset_input_pin_oe_n <= !drive_now;
      reset_output_pin_n   <= init_done_reg && !(seq_start || start_async);
      pdn_pulldown_en      <= !filtered_reset_input;
      if (seq_start || start_async)
        pdn_pullup_en <= 1'b0;
      else if (enter_run && power_down_config_bit)
        pdn_pullup_en <= 1'b1;
      system_reset_n       <= (state_next == ST_RUN);
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_EXIT]  = enter_run;
  assign ev_set[EV_LONG]  = enter_long;
  assign ev_set[EV_DEGEN] = degen;
  assign ev_set[EV_ASYNC] = start_async;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status_reg <= '0;
    else
      irq_status_reg <= ev_set | (irq_status_reg & ~(wr_ist ? wr_data[EV_W-1:0] : '0));
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_reg <= '0;
    else if (wr_msk)
      irq_mask_reg <= wr_data[EV_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status_reg & irq_mask_reg);
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic        aw_held_reg;
  logic [7:0]  aw_addr_reg;
  logic        w_held_reg;
  logic [31:0] w_data_reg;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_addr = aw_addr_reg;
  assign wr_data = w_data_reg;

  wire wr_mapped = (wr_addr == CONFIG_ADDR) || (wr_addr == IRQ_STATUS_ADDR) || (wr_addr == IRQ_MASK_ADDR);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held_reg && !aw_take;
      s_axi_wready  <= !w_held_reg && !w_take;
      if (aw_take)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end
    end
  end

  wire [31:0] cfg_word   = {27'h0, power_down_config_bit, bidir_reset_enable, 3'h0};
  wire [31:0] flags_word = {23'h0, init_done_reg, 3'h0, src_reg};
  wire        rd_cfg     = (s_axi_araddr == CONFIG_ADDR);
  wire        rd_flags   = (s_axi_araddr == FLAGS_ADDR);
  wire        rd_ist     = (s_axi_araddr == IRQ_STATUS_ADDR);
  wire        rd_msk     = (s_axi_araddr == IRQ_MASK_ADDR);
  wire        rd_mapped  = rd_cfg || rd_flags || rd_ist || rd_msk;
  wire [31:0] rd_word    = rd_cfg   ? cfg_word :
                           rd_flags ? flags_word :
                           rd_ist   ? {28'h0, irq_status_reg} :
                           rd_msk   ? {28'h0, irq_mask_reg} : 32'h0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // brc_top
`default_nettype wire

// File: sim/bidirectional_reset_control_test.sv
// Testbench for brc_top: register access, reset sequences, pin drive and flags.
// Assumes brc_pkg, brc_ext_reset and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module bidirectional_reset_control_test
  import brc_pkg::*;
;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rd;
  logic [1:0]  rsp;
  logic        sw_req = 1'h0, wdt_req = 1'h0, eoi = 1'h0, ext_access_n = 1'h1, ext_low = 1'h0, pdn_low = 1'h0;
  int          hold = 0, n_fail = 0, comparisons = 0;
  wire logic   awready, wready, bvalid, arready, rvalid, pin_o, pin_oe_n, rst_out_n;
  wire logic   pd_en, pu_en, srst_n, irq, rst_line, pdn;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;

  always #10 aclk = ~aclk;

  brc_top i_brc_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sw_reset_req(sw_req), .wdt_reset_req(wdt_req),
    .end_of_init_instruction(eoi), .reset_input_pin_i(rst_line), .reset_input_pin_o(pin_o),
    .reset_input_pin_oe_n(pin_oe_n), .reset_output_pin_n(rst_out_n), .reset_power_down_pin_i(pdn),
    .pdn_pulldown_en(pd_en), .pdn_pullup_en(pu_en), .external_access_pin_n(ext_access_n),
    .system_reset_n(srst_n), .irq(irq));

  brc_ext_reset i_brc_ext_reset (.aclk(aclk), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .ext_low(ext_low),
    .pdn_low(pdn_low), .hold_cycles(hold), .rst_in_line(rst_line), .pdn_line(pdn));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Waits as long as the slave needs; only the watchdog ends a hang
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end
    while (bvalid !== 1'h1);
    bready <= 1'h0;
    rsp = bresp;
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end
    while (rvalid !== 1'h1);
    rready <= 1'h0;
    rd = rdata;
    rsp = rresp;
    @(posedge aclk);
  endtask

  // Event pulse: 0 software reset, 1 watchdog, 2 end of init
  task automatic kick(input int k);
    if (k == 0) sw_req <= 1'h1;
    else if (k == 1) wdt_req <= 1'h1;
    else eoi <= 1'h1;
    @(posedge aclk);
    sw_req <= 1'h0;
    wdt_req <= 1'h0;
    eoi <= 1'h0;
    cyc(2);
  endtask

  task automatic wait_srst(input logic v);
    int t;
    t = 0;
    while (srst_n !== v && t < 3000)
    begin
      @(posedge aclk);
      t++;
    end
    `CHK(srst_n, v)
  endtask

  task automatic flags(input logic [4:0] e);
    cyc(20);
    rd_reg(FLAGS_ADDR);
    `CHK(rd[4:0], e)
  endtask

  task automatic tally_and_finish;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    cyc(6);
    aresetn <= 1'h1;
    cyc(2);
    flags(SRC_ASYNC);
    rd_reg(8'h10);
    `CHK({rsp, rd}, {RESP_SLVERR, 32'h0})
    wr(CONFIG_ADDR, 32'h07);
    rd_reg(CONFIG_ADDR);
    `CHK(rd[3], 1'h0)
    wr(CONFIG_ADDR, 32'h18);
    rd_reg(CONFIG_ADDR);
    `CHK(rd[4:3], 2'h3)
    $display("test registers done");
    hold <= 10;
    kick(0);
    `CHK({pin_oe_n, rst_out_n, srst_n}, 3'h0)
    wait_srst(1'h1);
    `CHK(pu_en, 1'h1)
    flags(SRC_SW);
    `CHK(srst_n, 1'h1)
    rd_reg(CONFIG_ADDR);
    `CHK(rd[3], 1'h0)
    `CHK(rst_out_n, 1'h0)
    $display("test software bidirectional done");
    wr(CONFIG_ADDR, 32'h08);
    ext_access_n <= 1'h0;
    kick(1);
    wait_srst(1'h1);
    wait_srst(1'h0);
    wait_srst(1'h1);
    flags(SRC_SHORT);
    `CHK(pu_en, 1'h0)
    `CHK(irq, 1'h0)
    wr(IRQ_MASK_ADDR, 32'h4);
    cyc(2);
    `CHK(irq, 1'h1)
    wr(IRQ_STATUS_ADDR, 32'h4);
    cyc(2);
    `CHK(irq, 1'h0)
    $display("test watchdog degeneration done");
    wr(CONFIG_ADDR, 32'h08);
    hold <= 0;
    pdn_low <= 1'h1;
    cyc(4);
    kick(0);
    `CHK(pin_oe_n, 1'h1)
    wait_srst(1'h1);
    pdn_low <= 1'h0;
    wr(CONFIG_ADDR, 32'h08);
    kick(0);
    cyc(100);
    `CHK(pin_oe_n, 1'h0)
    pdn_low <= 1'h1;
    cyc(4);
    `CHK({pin_oe_n, srst_n}, 2'h2)
    pdn_low <= 1'h0;
    cyc(900);
    `CHK(srst_n, 1'h0)
    wait_srst(1'h1);
    flags(SRC_SW);
    $display("test power-down pin done");
    wr(CONFIG_ADDR, 32'h08);
    ext_low <= 1'h1;
    cyc(10);
    ext_low <= 1'h0;
    `CHK(pin_oe_n, 1'h0)
    wait_srst(1'h1);
    flags(SRC_SHORT);
    wr(CONFIG_ADDR, 32'h08);
    hold <= 20;
    ext_low <= 1'h1;
    cyc(10);
    ext_low <= 1'h0;
    `CHK(pin_oe_n, 1'h0)
    wait_srst(1'h1);
    flags(SRC_LONG);
    hold <= 0;
    pdn_low <= 1'h1;
    ext_low <= 1'h1;
    cyc(10);
    `CHK(srst_n, 1'h0)
    ext_low <= 1'h0;
    pdn_low <= 1'h0;
    wait_srst(1'h1);
    flags(SRC_ASYNC);
    $display("test hardware resets done");
    `CHK(rst_out_n, 1'h0)
    kick(2);
    `CHK(rst_out_n, 1'h1)
    wr(CONFIG_ADDR, 32'h08);
    rd_reg(CONFIG_ADDR);
    `CHK(rd[3], 1'h0)
    kick(1);
    `CHK({pin_oe_n, rst_out_n}, 2'h2)
    wait_srst(1'h1);
    flags(SRC_WDT);
    $display("test end of init done");
    tally_and_finish;
  end

  initial
  begin
    cyc(40000);
    n_fail++;
    tally_and_finish;
  end
endmodule // bidirectional_reset_control_test
`default_nettype wire

// File: sim/brc_checker_sva.sv
// Checker for the bidirectional reset controller: port-level timing relations.
// Assumes it is bound to brc_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module brc_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus answers
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Pins and state
  input wire logic        end_of_init_instruction,
  input wire logic        reset_input_pin_i,
  input wire logic        reset_input_pin_o,
  input wire logic        reset_input_pin_oe_n,
  input wire logic        reset_output_pin_n,
  input wire logic        pdn_pulldown_en,
  input wire logic        pdn_pullup_en,
  input wire logic        system_reset_n
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  open_drain_a: assert property (!reset_input_pin_oe_n |-> !reset_input_pin_o)
    else $error("reset input pin driven high");
  drive_in_seq_a: assert property (!reset_input_pin_oe_n |-> !system_reset_n && !reset_output_pin_n)
    else $error("reset input pin pulled outside a sequence");
  drive_release_a: assert property ($rose(system_reset_n) |-> reset_input_pin_oe_n)
    else $error("pull-down still on at reset exit");
  out_low_start_a: assert property ($fell(system_reset_n) |-> ##[0:2] !reset_output_pin_n)
    else $error("reset output pin not low at sequence start");
  out_rise_eoi_a: assert property ($rose(reset_output_pin_n) |->
    ($past(end_of_init_instruction) || $past(end_of_init_instruction, 2)))
    else $error("reset output pin released without end of init");
  pulldown_on_a: assert property (!reset_input_pin_i [*4] |-> pdn_pulldown_en)
    else $error("power-down pull-down off while input low");
  pulldown_off_a: assert property (reset_input_pin_i [*4] |-> !pdn_pulldown_en)
    else $error("power-down pull-down on while input high");
  pullup_clear_a: assert property ($fell(system_reset_n) |-> ##[0:2] !pdn_pullup_en)
    else $error("power-down pull-up kept during sequence");
  short_detect_a: assert property ($fell(reset_input_pin_i) ##1 !reset_input_pin_i [*6]
    |=> !system_reset_n)
    else $error("low reset input not recognised");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");

  pin_drive_c: cover property ($fell(reset_input_pin_oe_n));
  eoi_c: cover property ($rose(reset_output_pin_n));
  exit_c: cover property ($rose(system_reset_n));
endmodule // brc_checker

bind brc_top brc_checker i_brc_checker (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .end_of_init_instruction, .reset_input_pin_i,
  .reset_input_pin_o, .reset_input_pin_oe_n, .reset_output_pin_n, .pdn_pulldown_en, .pdn_pullup_en,
  .system_reset_n);
`default_nettype wire

// File: sim/brc_ext_reset.sv
// External reset circuitry model: pulled-up reset line, capacitor stretch, power-down pin level.
// Assumes the bench drives its controls on aclk.
`timescale 1ns/1ps
`default_nettype none
module brc_ext_reset (
  // Clock
  input  wire logic        aclk,
  // Device open drain
  input  wire logic        pin_o,
  input  wire logic        pin_oe_n,
  // Bench controls
  input  wire logic        ext_low,
  input  wire logic        pdn_low,
  input  wire logic [31:0] hold_cycles,
  // Resolved lines
  output logic             rst_in_line,
  output logic             pdn_line
);
  int stretch = 0;

  // Slow release: the line stays low hold_cycles after the device lets go
  always @(posedge aclk)
  begin
    if (!pin_oe_n)
      stretch <= int'(hold_cycles);
    else if (stretch != 0)
      stretch <= stretch - 1;
  end

  assign rst_in_line = !(ext_low || (!pin_oe_n && !pin_o) || stretch != 0);
  assign pdn_line    = !pdn_low;
endmodule // brc_ext_reset
`default_nettype wire
